//--- tx_host_regs.sv
// transmit host register bank on apb with queue, counter and interrupt logic
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module tx_host_regs #(
	parameter int DEPTH = 32,
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic tx_char_valid,
	output logic [7:0] tx_char,
	input wire logic tx_char_taken,
	input wire logic frame_begin,
	input wire tx_regs_pkg::tx_events_t tx_events,
	output logic frame_permit,
	output logic char_count_active,
	output logic char_count_done,
	output logic irq,
	output logic tx_data_irq,
	output logic tx_dma_req,
	output logic baud1_tick
);
	localparam int CW = $clog2(DEPTH + 1);

	logic [5:0] idx;
	logic access;
	logic commit;
	logic wr;
	logic is_data;
	logic mapped;
	logic two_chars;
	logic any_lane;
	logic room_ok;
	logic [15:0] rd16;
	logic [15:0] wd16;
	logic [CW-1:0] level;
	logic [7:0] empty_count;
	logic [7:0] intctl_low_reg;
	logic [7:0] int_level_reg;
	logic [7:0] dma_level_reg;
	logic [7:0] upper_byte;
	logic [7:0] status_reg;
	logic [7:0] status_set;
	logic [7:0] status_clr;
	logic [15:0] count_limit_reg;
	logic [15:0] char_counter_reg;
	logic [15:0] tc_reg;
	logic [15:0] bg_count;
	logic high_first_reg;
	logic [3:0] cmd;
	logic [4:0] cmn;
	logic cmd_wr;
	logic push_first;
	logic push_second;
	logic [7:0] first_char;
	logic [7:0] second_char;
	tx_regs_pkg::upper_sel_t upper_sel_reg;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] strb);
		merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction : merge16

	assign idx = paddr[tx_regs_pkg::IDX_LSB +: tx_regs_pkg::IDX_W];
	assign access = psel && penable;
	assign commit = access && pready;
	assign wr = commit && pwrite;
	assign wd16 = pwdata[15:0];
	assign is_data = idx[tx_regs_pkg::ALT_SPACE_BIT]
		|| ((idx & tx_regs_pkg::DATA_MATCH_MASK) == tx_regs_pkg::DATA_MATCH_VALUE);
	assign mapped = is_data || idx == tx_regs_pkg::IDX_INT_CTL || idx == tx_regs_pkg::IDX_COUNT_LIMIT
		|| idx == tx_regs_pkg::IDX_CMD_STATUS || idx == tx_regs_pkg::IDX_COMMON_CMD
		|| idx == tx_regs_pkg::IDX_BAUD1 || idx == tx_regs_pkg::IDX_CHAR_COUNT;
	assign two_chars = pstrb[1] && pstrb[0];
	assign any_lane = pstrb[1] || pstrb[0];
	assign empty_count = 8'(DEPTH - int'(level));
	assign room_ok = !(pwrite && is_data) || (two_chars ? empty_count >= 8'h02 : empty_count >= 8'h01);

	// character ordering into the queue
	assign push_first = wr && is_data && any_lane;
	assign push_second = wr && is_data && two_chars;
	assign first_char = two_chars ? (high_first_reg ? wd16[15:8] : wd16[7:0])
		: (pstrb[0] ? wd16[7:0] : wd16[15:8]);
	assign second_char = high_first_reg ? wd16[7:0] : wd16[15:8];

	assign cmd = wd16[tx_regs_pkg::CMD_LSB +: 4];
	assign cmn = wd16[tx_regs_pkg::CMN_LSB +: 5];
	assign cmd_wr = wr && idx == tx_regs_pkg::IDX_CMD_STATUS && pstrb[1];

	tx_queue #(
		.WIDTH(8),
		.DEPTH(DEPTH)
	) u_queue (
		.clk(pclk),
		.rstn(presetn),
		.push_first(push_first),
		.first_data(first_char),
		.push_second(push_second),
		.second_data(second_char),
		.pop(tx_char_taken && tx_char_valid),
		.out_valid(tx_char_valid),
		.out_data(tx_char),
		.level(level)
	);

	baud_gen #(
		.WIDTH(16)
	) u_baud1 (
		.clk(pclk),
		.rstn(presetn),
		.time_constant(tc_reg),
		.count(bg_count),
		.tick(baud1_tick)
	);

	// upper byte of the interrupt control register
	always_comb begin
		unique case (upper_sel_reg)
			tx_regs_pkg::UPPER_FIFO: upper_byte = empty_count;
			tx_regs_pkg::UPPER_INT: upper_byte = int_level_reg;
			tx_regs_pkg::UPPER_DMA: upper_byte = dma_level_reg;
			default: upper_byte = empty_count;
		endcase
	end

	always_comb begin
		rd16 = 16'h0000;
		if (idx == tx_regs_pkg::IDX_INT_CTL) begin
			rd16 = {upper_byte, intctl_low_reg};
		end else if (idx == tx_regs_pkg::IDX_COUNT_LIMIT) begin
			rd16 = count_limit_reg;
		end else if (idx == tx_regs_pkg::IDX_CMD_STATUS) begin
			rd16 = {8'h00, status_reg[7:1], level == '0};
		end else if (idx == tx_regs_pkg::IDX_COMMON_CMD) begin
			rd16 = {15'h0000, high_first_reg};
		end else if (idx == tx_regs_pkg::IDX_BAUD1) begin
			rd16 = intctl_low_reg[tx_regs_pkg::BIT_BG_SEL] ? bg_count : tc_reg;
		end else if (idx == tx_regs_pkg::IDX_CHAR_COUNT) begin
			rd16 = char_counter_reg;
		end
	end

	// apb answer: one wait state, longer while the queue lacks room
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (access && !pready && room_ok) begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h00000000 : {16'h0000, rd16};
			pslverr <= !mapped;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_sel_reg <= tx_regs_pkg::UPPER_FIFO;
		end else if (cmd_wr) begin
			if (cmd == tx_regs_pkg::CMD_SEL_FIFO) begin
				upper_sel_reg <= tx_regs_pkg::UPPER_FIFO;
			end else if (cmd == tx_regs_pkg::CMD_SEL_INT) begin
				upper_sel_reg <= tx_regs_pkg::UPPER_INT;
			end else if (cmd == tx_regs_pkg::CMD_SEL_DMA) begin
				upper_sel_reg <= tx_regs_pkg::UPPER_DMA;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			intctl_low_reg <= tx_regs_pkg::INTCTL_LOW_RESET;
			int_level_reg <= tx_regs_pkg::LEVEL_RESET;
			dma_level_reg <= tx_regs_pkg::LEVEL_RESET;
		end else if (wr && idx == tx_regs_pkg::IDX_INT_CTL) begin
			if (pstrb[0]) begin
				intctl_low_reg <= wd16[7:0];
			end
			if (pstrb[1] && upper_sel_reg == tx_regs_pkg::UPPER_INT) begin
				int_level_reg <= wd16[15:8];
			end
			if (pstrb[1] && upper_sel_reg == tx_regs_pkg::UPPER_DMA) begin
				dma_level_reg <= wd16[15:8];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_limit_reg <= tx_regs_pkg::COUNT_LIMIT_RESET;
			tc_reg <= tx_regs_pkg::TC_RESET;
		end else if (wr) begin
			if (idx == tx_regs_pkg::IDX_COUNT_LIMIT) begin
				count_limit_reg <= merge16(count_limit_reg, wd16, pstrb[1:0]);
			end
			if (idx == tx_regs_pkg::IDX_BAUD1) begin
				tc_reg <= merge16(tc_reg, wd16, pstrb[1:0]);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_first_reg <= 1'b0;
		end else if (wr && idx == tx_regs_pkg::IDX_COMMON_CMD && pstrb[1]) begin
			if (cmn == tx_regs_pkg::CMN_HIGH_FIRST) begin
				high_first_reg <= 1'b1;
			end else if (cmn == tx_regs_pkg::CMN_LOW_FIRST) begin
				high_first_reg <= 1'b0;
			end
		end
	end

	// character counter loaded at each frame start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			char_counter_reg <= 16'h0000;
			char_count_active <= 1'b0;
			char_count_done <= 1'b0;
		end else if (frame_begin) begin
			char_counter_reg <= count_limit_reg;
			char_count_active <= count_limit_reg != 16'h0000;
			char_count_done <= 1'b0;
		end else if (char_count_active && tx_char_taken && tx_char_valid) begin
			char_counter_reg <= char_counter_reg - 16'h0001;
			char_count_active <= char_counter_reg != 16'h0001;
			char_count_done <= char_counter_reg == 16'h0001;
		end else begin
			char_count_done <= 1'b0;
		end
	end

	// frame hold; a send command in the same cycle as a frame start wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_permit <= 1'b0;
		end else if (!intctl_low_reg[tx_regs_pkg::BIT_HOLD]) begin
			frame_permit <= 1'b1;
		end else if (cmd_wr && cmd == tx_regs_pkg::CMD_SEND_FRAME) begin
			frame_permit <= 1'b1;
		end else if (frame_begin) begin
			frame_permit <= 1'b0;
		end
	end

	// sticky status, write one to clear, set wins
	always_comb begin
		status_set = 8'h00;
		status_set[tx_regs_pkg::ST_PRE] = tx_events.preamble;
		status_set[tx_regs_pkg::ST_IDLE] = tx_events.idle;
		status_set[tx_regs_pkg::ST_ABORT] = tx_events.abort;
		status_set[tx_regs_pkg::ST_EOF] = tx_events.end_frame;
		status_set[tx_regs_pkg::ST_CRC] = tx_events.check;
		status_set[tx_regs_pkg::ST_UNDER] = tx_events.underrun;
	end
	assign status_clr = (wr && idx == tx_regs_pkg::IDX_CMD_STATUS && pstrb[0]) ? wd16[7:0] : 8'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= 8'h00;
		end else begin
			status_reg <= ((status_reg & ~status_clr) | status_set) & tx_regs_pkg::STATUS_USED;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
			tx_data_irq <= 1'b0;
			tx_dma_req <= 1'b0;
		end else begin
			irq <= |(status_reg & intctl_low_reg & tx_regs_pkg::STATUS_USED);
			tx_data_irq <= empty_count > int_level_reg;
			tx_dma_req <= empty_count > dma_level_reg;
		end
	end
endmodule : tx_host_regs
`default_nettype wire

//--- tx_regs_pkg.sv
// constants, types and register map of the transmit host registers
package tx_regs_pkg;
	localparam int IDX_W = 6;
	localparam int IDX_LSB = 2;
	localparam logic [5:0] IDX_INT_CTL = 6'h1b;
	localparam logic [5:0] IDX_COUNT_LIMIT = 6'h1d;
	localparam logic [5:0] IDX_CMD_STATUS = 6'h0a;
	localparam logic [5:0] IDX_COMMON_CMD = 6'h0b;
	localparam logic [5:0] IDX_BAUD1 = 6'h0e;
	localparam logic [5:0] IDX_CHAR_COUNT = 6'h0f;
	localparam logic [5:0] DATA_MATCH_MASK = 6'h17;
	localparam logic [5:0] DATA_MATCH_VALUE = 6'h10;
	localparam int ALT_SPACE_BIT = 5;

	localparam int CMD_LSB = 12;
	localparam logic [3:0] CMD_SEL_FIFO = 4'h5;
	localparam logic [3:0] CMD_SEL_INT = 4'h6;
	localparam logic [3:0] CMD_SEL_DMA = 4'h7;
	localparam logic [3:0] CMD_SEND_FRAME = 4'h8;

	localparam int CMN_LSB = 11;
	localparam logic [4:0] CMN_HIGH_FIRST = 5'h0e;
	localparam logic [4:0] CMN_LOW_FIRST = 5'h0f;

	localparam int BIT_BG_SEL = 0;
	localparam int BIT_HOLD = 2;
	localparam int ST_PRE = 7;
	localparam int ST_IDLE = 6;
	localparam int ST_ABORT = 5;
	localparam int ST_EOF = 4;
	localparam int ST_CRC = 3;
	localparam int ST_UNDER = 1;
	localparam int ST_EMPTY = 0;
	localparam logic [7:0] STATUS_USED = 8'hfa;

	localparam logic [15:0] COUNT_LIMIT_RESET = 16'h0000;
	localparam logic [15:0] TC_RESET = 16'h0000;
	localparam logic [7:0] INTCTL_LOW_RESET = 8'h00;
	localparam logic [7:0] LEVEL_RESET = 8'h00;

	typedef enum logic [1:0] {UPPER_FIFO, UPPER_INT, UPPER_DMA} upper_sel_t;

	typedef struct packed {
		logic preamble;
		logic idle;
		logic abort;
		logic end_frame;
		logic check;
		logic underrun;
	} tx_events_t;
endpackage : tx_regs_pkg

//--- tx_queue.sv
// transmit character queue with one or two pushes per cycle and a registered head
`timescale 1ns/10ps
`default_nettype none
module tx_queue #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	parameter int AW = $clog2(DEPTH),
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic push_first,
	input wire logic [WIDTH-1:0] first_data,
	input wire logic push_second,
	input wire logic [WIDTH-1:0] second_data,
	input wire logic pop,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	output logic [CW-1:0] level
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_reg;
	logic [AW-1:0] rptr_reg;
	logic [CW-1:0] mem_cnt_reg;
	logic [CW-1:0] n_push;
	logic load;

	// second push is only legal together with the first
	assign n_push = CW'(push_first) + CW'(push_second);
	assign load = (mem_cnt_reg != '0) && (!out_valid || pop);
	assign level = mem_cnt_reg + CW'(out_valid);

	always_ff @(posedge clk) begin
		if (push_first) begin
			mem[wptr_reg] <= first_data;
		end
		if (push_second) begin
			mem[AW'(wptr_reg + AW'(1))] <= second_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			mem_cnt_reg <= '0;
		end else begin
			wptr_reg <= AW'(wptr_reg + AW'(n_push));
			rptr_reg <= AW'(rptr_reg + AW'(load));
			mem_cnt_reg <= CW'(mem_cnt_reg + n_push - CW'(load));
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			out_valid <= 1'b0;
			out_data <= '0;
		end else if (load) begin
			out_valid <= 1'b1;
			out_data <= mem[rptr_reg];
		end else if (pop) begin
			out_valid <= 1'b0;
		end
	end
endmodule : tx_queue
`default_nettype wire

//--- baud_gen.sv
// down-counting baud generator reloaded from its time constant
`timescale 1ns/10ps
`default_nettype none
module baud_gen #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] time_constant,
	output logic [WIDTH-1:0] count,
	output logic tick
);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count <= '0;
			tick <= 1'b0;
		end else if (count == '0) begin
			count <= time_constant;
			tick <= 1'b1;
		end else begin
			count <= count - WIDTH'(1);
			tick <= 1'b0;
		end
	end
endmodule : baud_gen
`default_nettype wire

//--- tx_host_regs_monitor.sv
// assertion checker for the transmit host register bank
`timescale 1ns/10ps
`default_nettype none
module tx_host_regs_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tx_char_valid,
	input wire logic [7:0] tx_char,
	input wire logic tx_char_taken,
	input wire logic frame_begin,
	input wire tx_regs_pkg::tx_events_t tx_events,
	input wire logic frame_permit,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence wr_done_s;
		pready && pwrite;
	endsequence
	a_ready_single: assert property (pready |=> !pready) else $error("pready held too long");
	a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error reply");
	a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000) else $error("upper read bits set");
	a_head_hold: assert property (tx_char_valid && !tx_char_taken |=> tx_char_valid && $stable(tx_char))
		else $error("queue head lost");
	a_irq_rise: assert property ($rose(irq) |-> $past(tx_events != 6'h00) || $past(tx_events != 6'h00, 2)
		|| $past(pready && pwrite) || $past(pready && pwrite, 2)) else $error("irq without cause");
	a_irq_fall: assert property ($fell(irq) |-> $past(pready && pwrite) || $past(pready && pwrite, 2))
		else $error("irq dropped without write");
	a_permit_fall: assert property ($fell(frame_permit) |-> $past(frame_begin)) else $error("permit dropped");
	a_permit_rise: assert property ($rose(frame_permit) |-> $past(!presetn) || $past(!presetn, 2) || $past(pready && pwrite)
		|| $past(pready && pwrite, 2)) else $error("permit rose without command");
	c_irq: cover property ($rose(irq));
	c_hold: cover property ($fell(frame_permit));
	c_err: cover property (pslverr);
	c_write: cover property (wr_done_s);
endmodule : tx_host_regs_monitor
bind tx_host_regs tx_host_regs_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_char_valid(tx_char_valid),
	.tx_char(tx_char), .tx_char_taken(tx_char_taken), .frame_begin(frame_begin), .tx_events(tx_events),
	.frame_permit(frame_permit), .irq(irq));
`default_nettype wire

//--- tx_serializer_model.sv
// serializer model that takes queued characters and reports events
`timescale 1ns/10ps
`default_nettype none
module tx_serializer_model (
	input wire logic pclk,
	input wire logic tx_char_valid,
	input wire logic [7:0] tx_char,
	input wire logic frame_permit,
	output logic tx_char_taken,
	output logic frame_begin,
	output var tx_regs_pkg::tx_events_t tx_events
);
	logic [7:0] got[$];
	initial begin
		tx_char_taken = 1'b0;
		frame_begin = 1'b0;
		tx_events = '0;
	end
	// random stalls on the take side
	always @(posedge pclk) begin
		if (tx_char_taken && tx_char_valid) got.push_back(tx_char);
		tx_char_taken <= ($urandom_range(0, 1) == 1);
	end
	task automatic start_frame();
		if (frame_permit) frame_begin <= 1'b1;
		@(posedge pclk);
		frame_begin <= 1'b0;
	endtask : start_frame
	task automatic pulse(input int j);
		tx_events <= 6'(1 << j);
		@(posedge pclk);
		tx_events <= '0;
	endtask : pulse
endmodule : tx_serializer_model
`default_nettype wire

//--- tx_host_regs_tb.sv
// self-checking bench for the transmit host register bank
`timescale 1ns/10ps
`default_nettype none
module tx_host_regs_tb;
	localparam int DEPTH = 8;
	localparam logic [7:0] DA [3] = '{8'h40, 8'h60, 8'hfc};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr, tx_char, t;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic tx_char_valid, tx_char_taken, frame_begin, frame_permit;
	logic char_count_active, char_count_done, irq, tx_data_irq, tx_dma_req, done_seen, baud1_tick;
	tx_regs_pkg::tx_events_t tx_events;
	logic [15:0] d, s;
	int miscompares, n_compared, b;
	tx_host_regs #(.DEPTH(DEPTH), .ADDR_W(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tx_char_valid(tx_char_valid), .tx_char(tx_char),
		.tx_char_taken(tx_char_taken), .frame_begin(frame_begin), .tx_events(tx_events),
		.frame_permit(frame_permit), .char_count_active(char_count_active), .char_count_done(char_count_done),
		.irq(irq), .tx_data_irq(tx_data_irq), .tx_dma_req(tx_dma_req), .baud1_tick(baud1_tick));
	tx_serializer_model pm (.pclk(pclk), .tx_char_valid(tx_char_valid), .tx_char(tx_char),
		.frame_permit(frame_permit), .tx_char_taken(tx_char_taken), .frame_begin(frame_begin),
		.tx_events(tx_events));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) if (char_count_done === 1'b1) done_seen <= 1'b1;
	function automatic logic [15:0] ord(input logic [15:0] v, input logic hf);
		return hf ? v : {v[7:0], v[15:8]};
	endfunction : ord
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic stop_test();
		if (miscompares == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] wd, input logic [3:0] s);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, wd};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (pready !== 1'b1) begin
			miscompares++;
			stop_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wait_got(input int k);
		int n;
		n = 0;
		while (pm.got.size() < k && n < 200) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 200) begin
			miscompares++;
			stop_test();
		end
	endtask : wait_got
	task automatic settle_chk(input string nm, input logic seen_sel, input logic exp);
		repeat (2) @(posedge pclk);
		chk(nm, {31'h0, seen_sel ? tx_dma_req : tx_data_irq}, {31'h0, exp});
	endtask : settle_chk
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = '0;
		pstrb = 4'h0;
		miscompares = 0;
		n_compared = 0;
		done_seen = 1'b0;
		void'($urandom(31849));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h6c, 16'h0000, 4'h0);
		chk("empty count", rd, {16'h0, 8'(DEPTH), 8'h00});
		chk("mapped no error", {31'h0, er}, 32'h0);
		chk("baud tick at zero constant", {31'h0, baud1_tick}, 32'h1);
		apb(1'b0, 8'h04, 16'h0000, 4'h0);
		chk("unmapped error", {31'h0, er}, 32'h1);
		for (int h = 0; h < 2; h++) begin
			apb(1'b1, 8'h2c, h ? 16'h7000 : 16'h7800, 4'h3);
			foreach (DA[i]) begin
				d = 16'($urandom());
				pm.got.delete();
				apb(1'b1, DA[i], d, 4'h3);
				wait_got(2);
				chk("char pair", {16'h0, pm.got[0], pm.got[1]}, {16'h0, ord(d, h[0])});
			end
		end
		// single-lane writes push only their own byte
		pm.got.delete();
		apb(1'b1, 8'h40, d, 4'h1);
		apb(1'b1, 8'h40, d, 4'h2);
		wait_got(2);
		chk("single lane chars", {16'h0, pm.got[0], pm.got[1]}, {16'h0, d[7:0], d[15:8]});
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, 8'h28, k ? 16'h7000 : 16'h6000, 4'h3);
			apb(1'b1, 8'h6c, {8'(DEPTH), 8'h00}, 4'h3);
			settle_chk("level at depth", k[0], 1'b0);
			t = 8'($urandom_range(0, DEPTH - 1));
			apb(1'b1, 8'h6c, {t, 8'h00}, 4'h3);
			settle_chk("level below", k[0], 1'b1);
			apb(1'b0, 8'h6c, 16'h0000, 4'h0);
			chk("level readback", rd, {16'h0, t, 8'h00});
		end
		apb(1'b1, 8'h28, 16'h5000, 4'h3);
		apb(1'b1, 8'h6c, 16'h0300, 4'h3);
		apb(1'b0, 8'h6c, 16'h0000, 4'h0);
		chk("empty read only", rd, {16'h0, 8'(DEPTH), 8'h00});
		for (int j = 0; j < 6; j++) begin
			b = (j == 0) ? 1 : j + 2;
			pm.pulse(j);
			repeat (3) @(posedge pclk);
			chk("masked irq", {31'h0, irq}, 32'h0);
			apb(1'b0, 8'h28, 16'h0000, 4'h0);
			chk("status bit", {31'h0, rd[b]}, 32'h1);
			apb(1'b1, 8'h6c, 16'(1 << b), 4'h1);
			repeat (2) @(posedge pclk);
			chk("armed irq", {31'h0, irq}, 32'h1);
			apb(1'b1, 8'h28, 16'(1 << b), 4'h1);
			repeat (2) @(posedge pclk);
			chk("cleared irq", {31'h0, irq}, 32'h0);
			apb(1'b1, 8'h6c, 16'h0000, 4'h1);
		end
		apb(1'b1, 8'h74, 16'h0003, 4'h3);
		pm.start_frame();
		repeat (2) @(posedge pclk);
		chk("counter on", {31'h0, char_count_active}, 32'h1);
		pm.got.delete();
		apb(1'b1, 8'h40, d, 4'h3);
		apb(1'b1, 8'h40, d, 4'h3);
		wait_got(4);
		@(posedge pclk);
		chk("count done", {31'h0, done_seen}, 32'h1);
		apb(1'b1, 8'h74, 16'h0000, 4'h3);
		pm.start_frame();
		repeat (2) @(posedge pclk);
		chk("counter off", {31'h0, char_count_active}, 32'h0);
		apb(1'b1, 8'h6c, 16'h0004, 4'h1);
		pm.start_frame();
		repeat (2) @(posedge pclk);
		chk("frame held", {31'h0, frame_permit}, 32'h0);
		apb(1'b1, 8'h28, 16'h8000, 4'h3);
		chk("frame released", {31'h0, frame_permit}, 32'h1);
		d = 16'($urandom_range(256, 65000));
		apb(1'b1, 8'h38, d, 4'h3);
		apb(1'b0, 8'h38, 16'h0000, 4'h0);
		chk("time constant", rd, {16'h0, d});
		apb(1'b1, 8'h6c, 16'h0001, 4'h1);
		apb(1'b0, 8'h38, 16'h0000, 4'h0);
		chk("count snapshot", {31'h0, rd[15:0] <= d}, 32'h1);
		s = rd[15:0];
		apb(1'b0, 8'h38, 16'h0000, 4'h0);
		chk("count moving", {31'h0, rd[15:0] != s}, 32'h1);
		stop_test();
	end
endmodule : tx_host_regs_tb
`default_nettype wire
